/* File: rgba_defines.svh */
// constants for the request/grant bus arbiter and its coprocessor end
`ifndef RGBA_DEFINES_SVH
`define RGBA_DEFINES_SVH

// ************************************************************
// timing
// ************************************************************
`define RGBA_CLK_PERIOD_NS   10
`define RGBA_RESET_MIN_CYC   4
`define RGBA_GRANT_DELAY     1
`define RGBA_CNT_W           3

// ************************************************************
// bus owner codes
// ************************************************************
`define RGBA_OWN_PROC        2'h0
`define RGBA_OWN_TAKE        2'h1
`define RGBA_OWN_CH0         2'h2
`define RGBA_OWN_CH1         2'h3

// ************************************************************
// policy and configuration values
// ************************************************************
`define RGBA_POLICY_RESET    1'h0
`define RGBA_CFG_MIN         1'h1

`endif

/* File: rgba_pkg.sv */
// types used by the emulated processor end of the request/grant bus arbiter
`default_nettype none
package rgba_pkg;
	typedef enum logic {
		rgba_serve_while_emulating,
		rgba_always_serve
	} rgba_policy_t;

	typedef enum logic [1:0] {
		rgba_own_proc,
		rgba_own_take,
		rgba_own_ch0,
		rgba_own_ch1
	} rgba_owner_t;
endpackage
`default_nettype wire

/* File: rgba_link_if.sv */
// interface joining the emulated processor end and the coprocessor end
`timescale 1ns/1ps
`default_nettype none
interface rgba_link_if;
	logic min_max_config;   // high: minimum mode
	logic ch0_dev_o;        // channel 0 / bus-take request, device side drive
	logic ch0_dev_oe;
	logic ch1_dev_o;        // channel 1 / bus-take ack, device side drive
	logic ch1_dev_oe;
	logic ch0_cop_o;
	logic ch0_cop_oe;
	logic ch1_cop_o;
	logic ch1_cop_oe;
	logic init_out_n;
	logic bus_drive_en;     // device drives the system bus
	// open-drain style wires: low whenever any end drives low
	logic req_grant_channel_0;
	logic req_grant_channel_1;
	assign req_grant_channel_0 = !((ch0_dev_oe && !ch0_dev_o) || (ch0_cop_oe && !ch0_cop_o));
	assign req_grant_channel_1 = !((ch1_dev_oe && !ch1_dev_o) || (ch1_cop_oe && !ch1_cop_o));

	modport device (
		input  min_max_config, req_grant_channel_0, req_grant_channel_1,
		output ch0_dev_o, ch0_dev_oe, ch1_dev_o, ch1_dev_oe, init_out_n, bus_drive_en
	);
	modport cop (
		input  min_max_config, req_grant_channel_0, req_grant_channel_1, init_out_n,
		output ch0_cop_o, ch0_cop_oe, ch1_cop_o, ch1_cop_oe
	);
endinterface
`default_nettype wire

/* File: rgba_cop.sv */
// coprocessor end: pulses requests and releases, or holds bus-take request
`timescale 1ns/1ps
`default_nettype none
`include "rgba_defines.svh"
module rgba_cop (
	input  wire logic      core_clk,
	input  wire logic      rstn,
	rgba_link_if.cop       link,
	input  wire logic      want_bus,
	input  wire logic      chan_sel,
	output logic           have_bus,
	output logic           in_reset
);
	typedef enum logic [2:0] {
		rgba_c_idle, rgba_c_req, rgba_c_wait, rgba_c_own, rgba_c_rel
	} rgba_cstate_t;

	typedef struct packed {
		rgba_cstate_t st;
		logic         ch;
		logic         pin_prev;
		logic         have;
		logic         rst;
	} rgba_cop_st_t;

	rgba_cop_st_t s_q, s_d;
	logic line;
	logic pulse_lo;

	// watch the channel this end uses
	assign line = s_q.ch ? link.req_grant_channel_1 : link.req_grant_channel_0;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		s_d = s_q;
		pulse_lo = 1'b0;
		s_d.pin_prev = line;
		s_d.rst = !link.init_out_n;
		if (link.min_max_config == `RGBA_CFG_MIN) begin
			// minimum mode: level request, ack seen on channel 1 pin
			s_d.st = rgba_c_idle;
			s_d.have = want_bus && !link.req_grant_channel_1; // see [R15]
		end else begin
			unique case (s_q.st)
				rgba_c_idle: begin
					if (want_bus) begin
						s_d.ch = chan_sel;
						s_d.st = rgba_c_req;
					end
				end
				rgba_c_req: begin
					pulse_lo = 1'b1;     // request pulse, see [R05]
					s_d.st = rgba_c_wait;
				end
				rgba_c_wait: begin
					// grant arrives as a low pulse on our own line
					if (!line && s_q.pin_prev) begin
						s_d.st = rgba_c_own;
						s_d.have = 1'b1;
					end
				end
				rgba_c_own: begin
					if (!want_bus) begin
						s_d.st = rgba_c_rel;
					end
				end
				rgba_c_rel: begin
					pulse_lo = 1'b1;     // release pulse returns bus, see [R07]
					s_d.have = 1'b0;
					s_d.st = rgba_c_idle;
				end
			endcase
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{st: rgba_c_idle, ch: 1'b0, pin_prev: 1'b1, have: 1'b0, rst: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// pin drives: request pulse in max mode, held request level in min mode
	always_comb begin
		link.ch0_cop_o  = 1'b1;
		link.ch0_cop_oe = 1'b0;
		link.ch1_cop_o  = 1'b1;
		link.ch1_cop_oe = 1'b0;
		if (link.min_max_config == `RGBA_CFG_MIN) begin
			link.ch0_cop_o  = !want_bus;
			link.ch0_cop_oe = 1'b1;
		end else if (pulse_lo) begin
			if (s_q.ch) begin
				link.ch1_cop_o  = 1'b0;
				link.ch1_cop_oe = 1'b1;
			end else begin
				link.ch0_cop_o  = 1'b0;
				link.ch0_cop_oe = 1'b1;
			end
		end
	end

	assign have_bus = s_q.have;
	assign in_reset = s_q.rst;
endmodule // rgba_cop
`default_nettype wire

/* File: rgba_dev.sv */
// emulated processor end: bus arbitration and coprocessor reset output
//
// Overview of operation
// [R01] Hardware reset pulse lasts at least four clocks.
// [R02] Outside keeps reset stable around emulation changes.
// [R03] Reset cut by halt is dropped, never replayed.
// [R04] Reset command drives init output low.
// [R05] Max mode transfer: request, grant, release pulses.
// [R06] Grant pulses the same line the request used.
// [R07] Coprocessor pulses again to return the bus.
// [R08] Always-serve policy grants in every mode.
// [R09] Emulation-only policy grants only while emulating.
// [R10] Requests outside emulation latched, granted on resume.
// [R11] Policy resets to emulation-only.
// [R12] Grant waits one clock after request; the code leaves a two clock gap.
// [R13] Bus drivers released one clock before grant.
// [R14] Minimum mode bus-take always served.
// [R15] Min mode: request input, acknowledge output.
// [R16] Max mode reuses bus-take pins as channels.
// [R17] Owner reported: processor, bus-take, channel 0, 1.
// [R18] Owner is two bits, updates on grant/release.
`timescale 1ns/1ps
`default_nettype none
`include "rgba_defines.svh"
module rgba_dev #(
	parameter int RESET_CYC = `RGBA_RESET_MIN_CYC
) (
	input  wire logic            core_clk,
	input  wire logic            rstn,
	rgba_link_if.device          link,
	input  wire logic            emulating,
	input  wire logic            reset_cmd,
	input  wire logic            policy_wr,
	input  wire logic            policy_val,
	output rgba_pkg::rgba_owner_t bus_owner,
	output logic                 arbitration_policy,
	output logic                 hw_reset_active
);
	typedef enum logic [2:0] {
		rgba_d_idle, rgba_d_pend, rgba_d_float, rgba_d_grant, rgba_d_held
	} rgba_dstate_t;

	typedef struct packed {
		rgba_dstate_t          st;
		logic                  ch;
		logic [1:0]            latched;
		logic [1:0]            prev;
		rgba_pkg::rgba_policy_t policy;
		rgba_pkg::rgba_owner_t  owner;
		logic [`RGBA_CNT_W-1:0] rst_cnt;
		logic                  drive;
	} rgba_dev_st_t;

	rgba_dev_st_t s_q, s_d;
	logic [1:0]   pins;
	logic [1:0]   fall;
	logic         may_serve;
	logic         grant_lo;

	assign pins = {link.req_grant_channel_1, link.req_grant_channel_0}; // see [R16]
	assign fall = s_q.prev & ~pins;

	// emulation-only policy blocks grants outside emulation
	assign may_serve = (s_q.policy == rgba_pkg::rgba_always_serve) || emulating; // see [R08] [R09]

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		s_d = s_q;
		grant_lo = 1'b0;
		s_d.prev = pins;
		if (policy_wr) begin
			s_d.policy = rgba_pkg::rgba_policy_t'(policy_val);
		end
		// reset counter: a halt does not cut the pulse, nothing is stored or replayed
		if (reset_cmd && s_q.rst_cnt == '0) begin
			s_d.rst_cnt = `RGBA_CNT_W'(RESET_CYC); // see [R01] [R04]
		end else if (s_q.rst_cnt != '0) begin
			// a halt neither saves nor restarts the pulse: it just runs out
			s_d.rst_cnt = s_q.rst_cnt - `RGBA_CNT_W'(1); // see [R03]
		end
		if (link.min_max_config == `RGBA_CFG_MIN) begin
			// hold/ack pair ignores policy and emulation state
			s_d.st = rgba_d_idle;
			s_d.latched = 2'h0;
			s_d.drive = !(!link.req_grant_channel_0); // see [R14] [R15]
			s_d.owner = !link.req_grant_channel_0 ? rgba_pkg::rgba_own_take
				: rgba_pkg::rgba_own_proc;
		end else begin
			unique case (s_q.st)
				rgba_d_idle: begin
					s_d.drive = 1'b1;
					// remember falls even while not serving
					s_d.latched = s_q.latched | fall; // see [R10]
					if ((s_q.latched[0] || s_q.latched[1]) && may_serve) begin
						s_d.ch = !s_q.latched[0];
						s_d.st = rgba_d_pend;
						s_d.drive = 1'b0;            // float a clock before grant, see [R13]
					end
				end
				rgba_d_pend: begin
					// two clock gap keeps request and grant apart
					s_d.st = rgba_d_float;           // see [R12]
					s_d.drive = 1'b0;                // see [R13]
				end
				rgba_d_float: begin
					grant_lo = 1'b1;                 // see [R05] [R06]
					s_d.latched[s_q.ch] = 1'b0;
					s_d.owner = s_q.ch ? rgba_pkg::rgba_own_ch1
						: rgba_pkg::rgba_own_ch0;    // see [R17] [R18]
					s_d.st = rgba_d_grant;
				end
				rgba_d_grant: begin
					s_d.st = rgba_d_held;            // skip our own grant edge
				end
				rgba_d_held: begin
					if (fall[s_q.ch]) begin
						s_d.st = rgba_d_idle;        // see [R07]
						s_d.owner = rgba_pkg::rgba_own_proc;
						s_d.drive = 1'b1;
					end
					s_d.latched[!s_q.ch] = s_q.latched[!s_q.ch] | fall[!s_q.ch];
				end
				default: begin
					s_d.st = rgba_d_idle;
				end
			endcase
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{st: rgba_d_idle, ch: 1'b0, latched: 2'h0, prev: 2'h3,
				policy: rgba_pkg::rgba_policy_t'(`RGBA_POLICY_RESET), // see [R11]
				owner: rgba_pkg::rgba_own_proc, rst_cnt: '0, drive: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	// pin drives: grant pulse in max mode, ack level in min mode
	always_comb begin
		link.ch0_dev_o  = 1'b1;
		link.ch0_dev_oe = 1'b0;
		link.ch1_dev_o  = 1'b1;
		link.ch1_dev_oe = 1'b0;
		if (link.min_max_config == `RGBA_CFG_MIN) begin
			link.ch1_dev_o  = s_q.owner != rgba_pkg::rgba_own_take;
			link.ch1_dev_oe = 1'b1;
		end else if (grant_lo) begin
			if (s_q.ch) begin
				link.ch1_dev_o  = 1'b0;
				link.ch1_dev_oe = 1'b1;
			end else begin
				link.ch0_dev_o  = 1'b0;
				link.ch0_dev_oe = 1'b1;
			end
		end
	end

	assign link.init_out_n    = !(s_q.rst_cnt != '0);
	assign link.bus_drive_en  = s_q.drive;
	assign bus_owner          = s_q.owner;
	assign arbitration_policy = s_q.policy;
	assign hw_reset_active    = s_q.rst_cnt != '0;
endmodule // rgba_dev
`default_nettype wire

/* File: rgba_props.sv */
// assertions on the link between the arbiter and its coprocessor
`timescale 1ns/1ps
`default_nettype none
module rgba_props #(
	parameter int RESET_CYC = 4
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic min_max_config,
	input wire logic req_grant_channel_0,
	input wire logic req_grant_channel_1,
	input wire logic init_out_n,
	input wire logic bus_drive_en
);
	// ********
	// helpers
	// ********
	logic [7:0] low_q;
	logic       both_hi;
	// both lines idle high, no pulse on either
	assign both_hi = req_grant_channel_0 && req_grant_channel_1;
	// run length of the init pulse so far
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			low_q <= 8'h00;
		else
			low_q <= init_out_n ? 8'h00 : low_q + 8'h01;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// ********
	// checks
	// ********
	a_init_len_exact: assert property ($rose(init_out_n) |-> int'(low_q) == RESET_CYC)
		else $error("init pulse length wrong");
	a_init_not_long: assert property (!init_out_n |-> int'(low_q) < RESET_CYC)
		else $error("init pulse too long");
	a_gap_ch0: assert property ((!min_max_config && bus_drive_en && $fell(req_grant_channel_0))
		|-> ##1 req_grant_channel_0 [*2])
		else $error("grant on channel 0 too early");
	a_gap_ch1: assert property ((!min_max_config && bus_drive_en && $fell(req_grant_channel_1))
		|-> ##1 req_grant_channel_1 [*2])
		else $error("grant on channel 1 too early");
	a_float_first: assert property ((!min_max_config && $fell(bus_drive_en))
		|-> both_hi ##1 !both_hi)
		else $error("bus not floated one cycle before grant");
	a_return_after_pulse: assert property ($rose(bus_drive_en)
		|-> !($past(both_hi) && $past(both_hi, 2)))
		else $error("bus taken back without release pulse");
	a_take_ack: assert property ((min_max_config && $fell(req_grant_channel_0))
		|-> ##[1:2] (!req_grant_channel_1 && !bus_drive_en))
		else $error("bus-take not acknowledged");
	a_take_drop: assert property ((min_max_config && $rose(req_grant_channel_0))
		|-> ##[1:2] (req_grant_channel_1 && bus_drive_en))
		else $error("bus-take ack not withdrawn");
endmodule // rgba_props
`default_nettype wire

/* File: tb_request_grant_bus_arbiter.sv */
// self-checking bench: both arbiter ends joined over the link
`timescale 1ns/1ps
`default_nettype none
`include "rgba_defines.svh"
module tb_request_grant_bus_arbiter;
	logic                  core_clk, rstn, emulating, reset_cmd, policy_wr, policy_val;
	logic                  want_bus, chan_sel, arbitration_policy, have_bus;
	logic                  hw_rst, cop_rst;
	int                    act_cnt, cop_cnt;
	rgba_pkg::rgba_owner_t bus_owner;
	int                    bad_count, samples_checked, n, low_cnt;
	rgba_link_if i_rgba_link_if ();
	rgba_dev #(.RESET_CYC(`RGBA_RESET_MIN_CYC)) i_rgba_dev (.core_clk(core_clk), .rstn(rstn),
		.link(i_rgba_link_if), .emulating(emulating), .reset_cmd(reset_cmd),
		.policy_wr(policy_wr), .policy_val(policy_val), .bus_owner(bus_owner),
		.arbitration_policy(arbitration_policy), .hw_reset_active(hw_rst));
	rgba_cop i_rgba_cop (.core_clk(core_clk), .rstn(rstn), .link(i_rgba_link_if),
		.want_bus(want_bus), .chan_sel(chan_sel), .have_bus(have_bus), .in_reset(cop_rst));
	rgba_props #(.RESET_CYC(`RGBA_RESET_MIN_CYC)) i_rgba_props (.core_clk(core_clk),
		.rstn(rstn), .min_max_config(i_rgba_link_if.min_max_config),
		.req_grant_channel_0(i_rgba_link_if.req_grant_channel_0),
		.req_grant_channel_1(i_rgba_link_if.req_grant_channel_1),
		.init_out_n(i_rgba_link_if.init_out_n), .bus_drive_en(i_rgba_link_if.bus_drive_en));
	// ********
	// clock, pulse counter, watchdog
	// ********
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	// counts init low cycles, cleared by the scenario
	always @(negedge core_clk) begin
		if (i_rgba_link_if.init_out_n === 1'h0) low_cnt++;
		if (hw_rst === 1'h1) act_cnt++;
		if (cop_rst === 1'h1) cop_cnt++;
	end
	// whole run needs well under a thousand cycles
	initial begin
		#100000;
		bad_count++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		finish_test();
	end
	// ********
	// helpers
	// ********
	task automatic chk(input bit ok, input string m);
		samples_checked++;
		if (!ok) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic wait_have(input logic v);
		for (n = 0; n < 40 && have_bus !== v; n++) @(negedge core_clk);
		chk(have_bus === v, "handshake timed out");
	endtask
	// release and wait for the processor to own the bus again
	task automatic drop();
		@(posedge core_clk) want_bus <= 1'h0;
		wait_have(1'h0);
		for (n = 0; n < 10 && bus_owner !== rgba_pkg::rgba_own_proc; n++) @(negedge core_clk);
		chk(bus_owner === rgba_pkg::rgba_own_proc, "owner after release");
	endtask
	task automatic xfer(input logic c, input rgba_pkg::rgba_owner_t o);
		@(posedge core_clk);
		want_bus <= 1'h1;
		chan_sel <= c;
		wait_have(1'h1);
		chk(bus_owner === o && i_rgba_link_if.bus_drive_en === 1'h0, "owner after grant");
		drop();
	endtask
	task automatic set_pol(input logic v);
		@(posedge core_clk);
		policy_wr <= 1'h1;
		policy_val <= v;
		@(posedge core_clk) policy_wr <= 1'h0;
		@(negedge core_clk);
		chk(arbitration_policy === v, "policy write");
	endtask
	// ********
	// scenarios
	// ********
	task automatic t_rst();
		chk(bus_owner === rgba_pkg::rgba_own_proc, "owner at reset");
		chk(arbitration_policy === `RGBA_POLICY_RESET, "policy at reset");
		$display("test reset values done");
	endtask
	// repeat command and a halt mid pulse must not stretch or replay it
	task automatic t_init();
		low_cnt = 0;
		act_cnt = 0;
		cop_cnt = 0;
		// second command cycle lands while counting and is ignored
		@(posedge core_clk) reset_cmd <= 1'h1;
		@(posedge core_clk);
		@(posedge core_clk) reset_cmd <= 1'h0;
		// halt mid pulse; command level stays steady around it
		@(posedge core_clk) emulating <= 1'h0;
		@(posedge core_clk) emulating <= 1'h1;
		repeat (20) @(negedge core_clk);
		chk(low_cnt === `RGBA_RESET_MIN_CYC, "init pulse length");
		chk(act_cnt === `RGBA_RESET_MIN_CYC, "reset active length");
		chk(cop_cnt === `RGBA_RESET_MIN_CYC, "coprocessor reset length");
		$display("test init pulse done");
	endtask
	task automatic t_max();
		xfer(1'h0, rgba_pkg::rgba_own_ch0);
		xfer(1'h1, rgba_pkg::rgba_own_ch1);
		$display("test channels done");
	endtask
	task automatic t_hold();
		@(posedge core_clk);
		emulating <= 1'h0;
		want_bus <= 1'h1;
		chan_sel <= 1'h0;
		repeat (20) @(negedge core_clk);
		chk(have_bus === 1'h0 && bus_owner === rgba_pkg::rgba_own_proc, "granted idle");
		@(posedge core_clk) emulating <= 1'h1;
		wait_have(1'h1);
		chk(bus_owner === rgba_pkg::rgba_own_ch0, "latched request owner");
		drop();
		$display("test held request done");
	endtask
	task automatic t_always();
		@(posedge core_clk) emulating <= 1'h0;
		set_pol(1'h1);
		xfer(1'h1, rgba_pkg::rgba_own_ch1);
		$display("test always serve done");
	endtask
	// bus-take served even when idle and emulation-only
	task automatic t_min();
		set_pol(1'h0);
		@(posedge core_clk) i_rgba_link_if.min_max_config <= `RGBA_CFG_MIN;
		repeat (2) @(negedge core_clk);
		xfer(1'h0, rgba_pkg::rgba_own_take);
		$display("test bus-take done");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ********
	// main sequence
	// ********
	initial begin
		{rstn, reset_cmd, policy_wr, policy_val, want_bus, chan_sel} = 6'h00;
		emulating = 1'h1;
		i_rgba_link_if.min_max_config = 1'h0;
		bad_count = 0;
		samples_checked = 0;
		repeat (10) @(posedge core_clk);
		rstn <= 1'h1;
		repeat (2) @(negedge core_clk);
		t_rst();
		t_init();
		t_max();
		t_hold();
		t_always();
		t_min();
		finish_test();
	end
endmodule // tb_request_grant_bus_arbiter
`default_nettype wire
